// >>> pkg/buck_regs_pkg.sv
// Purpose: constants for the regulator control register bank
// Assumes: 50 MHz clock, byte-wide registers, six-bit register address
// Notes:   factory power-on values are parameters of the top module
//
// Notes on behaviour
// - on-time code picks switching frequency
// - bit 4 picks 3.5A or 5A limit
// - delay code gives 250us, 1, 2, 3 ms
// - bit 1 picks register or pin enable
// - register enable bit turns regulator on/off
// - duty bit set blocks full duty cycle
// - mode bit picks light-load or forced switching
// - slew code gives 200 to 3200 us/V
// - codes up to 0x76 mean 0.6V
// - code 0x77 is 0.6V, 5mV per step
// - factory fields loaded, others cleared at power-on
// - only low six command bits address registers
// - unmapped address reads back all zeros
`default_nettype none

package buck_regs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam int          ADDR_W          = 6;
    localparam logic [5:0]  REG_CTRL_ONE    = 6'h00;
    localparam logic [5:0]  REG_CTRL_TWO    = 6'h01;
    localparam logic [5:0]  REG_VOUT_CODE   = 6'h02;

    // field positions, first control register
    localparam int          ON_TIME_LSB     = 6;
    localparam int          PEAK_CURRENT_LIMIT_SELECT_BIT        = 4;
    localparam int          DELAY_LSB       = 2;
    localparam int          EN_SRC_BIT      = 1;
    localparam int          EN_BIT          = 0;
    localparam logic [7:0]  CTRL_ONE_WMASK  = 8'hDF;
    localparam logic [7:0]  CTRL_ONE_FMASK  = 8'hD0;

    // field positions, second control register
    localparam int          FULL_DUTY_BIT   = 7;
    localparam int          FORCED_BIT      = 6;
    localparam int          OT_POLICY_BIT   = 5;
    localparam int          DISCHARGE_BIT   = 4;
    localparam int          SLEW_LSB        = 0;
    localparam logic [7:0]  CTRL_TWO_FMASK  = 8'h3F;

    ////////////////////////////////////////////////////////////////////////
    // voltage code decode
    localparam logic [7:0]  VOUT_MIN_CODE   = 8'h77;
    localparam logic [10:0] VOUT_MIN_MV     = 11'h258;
    localparam logic [10:0] VOUT_STEP_MV    = 11'h005;

    // overheat events before a deferred latch-off
    localparam logic [2:0]  OVERHEAT_LATCH_POLICY_COUNT  = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int          CLK_MHZ         = 50;
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          DELAY0_US       = 250;
    localparam int          DELAY1_US       = 1000;
    localparam int          DELAY2_US       = 2000;
    localparam int          DELAY3_US       = 3000;
    localparam int          DELAY0_CYC      = DELAY0_US * CLK_MHZ;
    localparam int          DELAY1_CYC      = DELAY1_US * CLK_MHZ;
    localparam int          DELAY2_CYC      = DELAY2_US * CLK_MHZ;
    localparam int          DELAY3_CYC      = DELAY3_US * CLK_MHZ;
    localparam int          DELAY_CNT_W     = 18;
    // 200 us/V per slew step means 1000 ns per 5 mV code step
    localparam int          SLEW_UNIT_NS    = 1000;
    localparam int          SLEW_UNIT_CYC   = SLEW_UNIT_NS / CLK_PERIOD_NS;
    localparam int          SLEW_CNT_W      = 10;

    typedef enum logic [1:0] {
        SEQ_OFF   = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_ON    = 2'b11
    } seq_state_t;

endpackage : buck_regs_pkg

`default_nettype wire

// >>> pkg/regulator_ctrl_if.sv
// Purpose: control fields between bank, sequencer and ramp
// Assumes: one clock domain
// Notes:   top drives requests, leaf modules drive their state back
`default_nettype none

interface regulator_ctrl_if;
    logic        enable_req;
    logic [1:0]  delay_sel;
    logic        latch_off;
    logic        regulator_on;
    logic [3:0]  slew_sel;
    logic [7:0]  target_code;
    logic [7:0]  applied_code;

    modport bank (output enable_req, delay_sel, latch_off, slew_sel, target_code,
                  input regulator_on, applied_code);
    modport seq  (input enable_req, delay_sel, latch_off, output regulator_on);
    modport ramp (input regulator_on, slew_sel, target_code, output applied_code);
endinterface : regulator_ctrl_if

`default_nettype wire

// >>> verilog/turn_on_sequencer.sv
// Purpose: turn-on delay and on/off state of the regulator
// Assumes: requests come from the register bank
// Notes:   delay counts are passed in so simulation can shorten them
`default_nettype none

module turn_on_sequencer #(
    parameter logic [17:0] DLY0 = 18'h0_30D4,
    parameter logic [17:0] DLY1 = 18'h0_C350,
    parameter logic [17:0] DLY2 = 18'h1_86A0,
    parameter logic [17:0] DLY3 = 18'h2_49F0
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    regulator_ctrl_if.seq          ctl
);
    import buck_regs_pkg::*;

    seq_state_t             state_r;
    seq_state_t             state_nxt;
    logic [DELAY_CNT_W-1:0] cnt_r;
    logic [DELAY_CNT_W-1:0] cnt_nxt;
    logic [DELAY_CNT_W-1:0] dly_len;
    logic                   go;

    // latch-off overrides the request; a new request restarts the delay
    assign go      = ctl.enable_req && !ctl.latch_off;
    assign dly_len = (ctl.delay_sel == 2'h0) ? DLY0 :
                     (ctl.delay_sel == 2'h1) ? DLY1 :
                     (ctl.delay_sel == 2'h2) ? DLY2 : DLY3;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            SEQ_OFF:
            begin
                cnt_nxt = '0;
                if (go)
                    state_nxt = SEQ_DELAY;
            end
            SEQ_DELAY:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (!go)
                    state_nxt = SEQ_OFF;
                else if (cnt_nxt >= dly_len)
                    state_nxt = SEQ_ON;
            end
            SEQ_ON:
            begin
                if (!go)
                    state_nxt = SEQ_OFF;
            end
            default:
                state_nxt = SEQ_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= SEQ_OFF;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign ctl.regulator_on = (state_r == SEQ_ON);

endmodule // turn_on_sequencer

`default_nettype wire

// >>> verilog/output_ramp.sv
// Purpose: steps the applied code toward the target
// Assumes: one code step is 5 mV
// Notes:   restarts at the minimum code while off
`default_nettype none

module output_ramp (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    regulator_ctrl_if.ramp         ctl
);
    import buck_regs_pkg::*;

    logic [SLEW_CNT_W-1:0] tick_r;
    logic [SLEW_CNT_W-1:0] step_len;
    logic [7:0]            code_r;
    logic [7:0]            goal;
    logic                  step;

    // below the floor every code means 0.6V, so ramp toward the floor
    assign goal     = (ctl.target_code < VOUT_MIN_CODE) ? VOUT_MIN_CODE
                                                        : ctl.target_code;
    // one more unit per slew code
    assign step_len = SLEW_CNT_W'((ctl.slew_sel + 1) * SLEW_UNIT_CYC);
    assign step     = (tick_r >= step_len - 1'b1);

    always_ff @(posedge clk)
    begin
        if (sys_rst || !ctl.regulator_on)
        begin
            tick_r <= '0;
            code_r <= VOUT_MIN_CODE;
        end
        else if (step)
        begin
            tick_r <= '0;
            if (code_r < goal)
                code_r <= code_r + 1'b1;
            else if (code_r > goal)
                code_r <= code_r - 1'b1;
        end
        else
            tick_r <= tick_r + 1'b1;
    end

    assign ctl.applied_code = code_r;

endmodule // output_ramp

`default_nettype wire

// >>> verilog/buck_regulator_control_registers.sv
// Purpose: control register bank of a programmable step-down regulator
// Assumes: a serial engine supplies command, write and read strobes
// Notes:   factory power-on values are parameters
`default_nettype none

module buck_regulator_control_registers #(
    parameter logic [7:0]  FACTORY_CTRL_ONE = 8'h50,
    parameter logic [7:0]  FACTORY_CTRL_TWO = 8'h30,
    parameter logic [7:0]  FACTORY_VOUT     = 8'hB3,
    parameter logic [17:0] DELAY0_CYCLES    = 18'(buck_regs_pkg::DELAY0_CYC),
    parameter logic [17:0] DELAY1_CYCLES    = 18'(buck_regs_pkg::DELAY1_CYC),
    parameter logic [17:0] DELAY2_CYCLES    = 18'(buck_regs_pkg::DELAY2_CYC),
    parameter logic [17:0] DELAY3_CYCLES    = 18'(buck_regs_pkg::DELAY3_CYC)
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        wr_valid,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_req,
    output logic [7:0]       rd_data,
    output logic             rd_ack,
    input  wire logic        enable_pin,
    input  wire logic        overtemperature,
    output logic [1:0]       on_time_select,
    output logic             peak_current_limit_select,
    output logic             full_duty_disable,
    output logic             forced_switching_mode,
    output logic             light_load_mode,
    output logic             regulator_on,
    output logic             latch_off,
    output logic             output_discharge_on,
    output logic [10:0]      target_mv,
    output logic [10:0]      applied_mv
);
    import buck_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // code to millivolt
    function automatic logic [10:0] code_to_mv(input logic [7:0] code);
        logic [7:0] steps;
        steps = (code < VOUT_MIN_CODE) ? 8'h00 : code - VOUT_MIN_CODE;
        return VOUT_MIN_MV + 11'(steps * VOUT_STEP_MV);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0]        ctrl_one_r;
    logic [7:0]        ctrl_two_r;
    logic [7:0]        vout_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0]        rd_data_r;
    logic              rd_ack_r;
    logic              ot_prev_r;
    logic [2:0]        ot_cnt_r;
    logic              latch_r;
    logic [1:0]        on_time_r;
    logic              peak_current_limit_select_r;
    logic              full_duty_r;
    logic              forced_r;
    logic              light_r;
    logic              reg_on_r;
    logic              discharge_r;
    logic [10:0]       target_mv_r;
    logic [10:0]       applied_mv_r;

    regulator_ctrl_if ctl ();

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic        hit_one;
    logic        hit_two;
    logic        hit_vout;
    logic [7:0]  rd_sel;
    logic        en_src_pin;
    logic        en_req;
    logic        ot_rise;
    logic        ot_policy;

    assign hit_one  = (addr_r == REG_CTRL_ONE);
    assign hit_two  = (addr_r == REG_CTRL_TWO);
    assign hit_vout = (addr_r == REG_VOUT_CODE);
    // reserved bit masked on read too
    assign rd_sel   = hit_one  ? (ctrl_one_r & CTRL_ONE_WMASK) :
                      hit_two  ? ctrl_two_r :
                      hit_vout ? vout_r : 8'h00;

    assign en_src_pin = ctrl_one_r[EN_SRC_BIT];
    assign en_req     = en_src_pin ? enable_pin : ctrl_one_r[EN_BIT];
    assign ot_rise    = overtemperature && !ot_prev_r;
    assign ot_policy  = ctrl_two_r[OT_POLICY_BIT];

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_one_r <= FACTORY_CTRL_ONE & CTRL_ONE_FMASK;
            ctrl_two_r <= FACTORY_CTRL_TWO & CTRL_TWO_FMASK;
            vout_r     <= FACTORY_VOUT;
            addr_r     <= '0;
        end
        else
        begin
            if (cmd_valid)
                addr_r <= cmd_byte[ADDR_W-1:0];
            if (wr_valid && hit_one)
                ctrl_one_r <= wr_data & CTRL_ONE_WMASK;
            if (wr_valid && hit_two)
                ctrl_two_r <= wr_data;
            if (wr_valid && hit_vout)
                vout_r <= wr_data;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rd_data_r <= 8'h00;
            rd_ack_r  <= 1'b0;
        end
        else
        begin
            rd_ack_r <= rd_req;
            if (rd_req)
                rd_data_r <= rd_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overheat latch; only a dropped enable clears it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ot_prev_r <= 1'b0;
            ot_cnt_r  <= 3'h0;
            latch_r   <= 1'b0;
        end
        else
        begin
            ot_prev_r <= overtemperature;
            if (!en_req)
            begin
                ot_cnt_r <= 3'h0;
                latch_r  <= 1'b0;
            end
            else if (ot_rise)
            begin
                if (ot_cnt_r != OVERHEAT_LATCH_POLICY_COUNT)
                    ot_cnt_r <= ot_cnt_r + 1'b1;
                if (!ot_policy || ot_cnt_r == OVERHEAT_LATCH_POLICY_COUNT - 1'b1)
                    latch_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and ramp
    assign ctl.enable_req  = en_req;
    assign ctl.delay_sel   = ctrl_one_r[DELAY_LSB +: 2];
    assign ctl.latch_off   = latch_r;
    assign ctl.slew_sel    = ctrl_two_r[SLEW_LSB +: 4];
    assign ctl.target_code = vout_r;

    turn_on_sequencer #(
        .DLY0 (DELAY0_CYCLES),
        .DLY1 (DELAY1_CYCLES),
        .DLY2 (DELAY2_CYCLES),
        .DLY3 (DELAY3_CYCLES)
    ) u_seq (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ctl     (ctl.seq)
    );

    output_ramp u_ramp (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ctl     (ctl.ramp)
    );

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            on_time_r    <= 2'h0;
            peak_current_limit_select_r       <= 1'b0;
            full_duty_r  <= 1'b0;
            forced_r     <= 1'b0;
            light_r      <= 1'b0;
            reg_on_r     <= 1'b0;
            discharge_r  <= 1'b0;
            target_mv_r  <= VOUT_MIN_MV;
            applied_mv_r <= VOUT_MIN_MV;
        end
        else
        begin
            on_time_r    <= ctrl_one_r[ON_TIME_LSB +: 2];
            peak_current_limit_select_r       <= ctrl_one_r[PEAK_CURRENT_LIMIT_SELECT_BIT];
            full_duty_r  <= ctrl_two_r[FULL_DUTY_BIT];
            forced_r     <= ctrl_two_r[FORCED_BIT];
            light_r      <= !ctrl_two_r[FORCED_BIT];
            reg_on_r     <= ctl.regulator_on;
            discharge_r  <= ctrl_two_r[DISCHARGE_BIT] && !ctl.regulator_on;
            target_mv_r  <= code_to_mv(vout_r);
            applied_mv_r <= code_to_mv(ctl.applied_code);
        end
    end

    assign rd_data                   = rd_data_r;
    assign rd_ack                    = rd_ack_r;
    assign on_time_select            = on_time_r;
    assign peak_current_limit_select = peak_current_limit_select_r;
    assign full_duty_disable         = full_duty_r;
    assign forced_switching_mode     = forced_r;
    assign light_load_mode           = light_r;
    assign regulator_on              = reg_on_r;
    assign latch_off                 = latch_r;
    assign output_discharge_on       = discharge_r;
    assign target_mv                 = target_mv_r;
    assign applied_mv                = applied_mv_r;

endmodule // buck_regulator_control_registers

`default_nettype wire

// >>> tb/buck_regs_asserts.sv
// Purpose: port-level checks of the regulator control register bank
// Assumes: one clock, synchronous active-high reset
// Notes:   keeps its own copy of the register address
`default_nettype none

module buck_regs_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_byte,
    input wire logic        wr_valid,
    input wire logic [7:0]  wr_data,
    input wire logic        rd_req,
    input wire logic [7:0]  rd_data,
    input wire logic        rd_ack,
    input wire logic        overtemperature,
    input wire logic [1:0]  on_time_select,
    input wire logic        peak_current_limit_select,
    input wire logic        full_duty_disable,
    input wire logic        forced_switching_mode,
    input wire logic        light_load_mode,
    input wire logic        regulator_on,
    input wire logic        latch_off,
    input wire logic        output_discharge_on,
    input wire logic [10:0] target_mv,
    input wire logic [10:0] applied_mv
);
    import buck_regs_pkg::*;

    logic [5:0] addr_r;
    wire        wr_one = wr_valid && (addr_r == REG_CTRL_ONE);
    wire        wr_two = wr_valid && (addr_r == REG_CTRL_TWO);
    wire        wr_vo  = wr_valid && (addr_r == REG_VOUT_CODE);

    // a write beside a command uses the old address
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            addr_r <= 6'h00;
        else if (cmd_valid)
            addr_r <= cmd_byte[5:0];
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    property p_on_time;
        logic [7:0] d;
        (wr_one, d = wr_data) |-> ##2 on_time_select == d[7:6];
    endproperty
    a_on_time: assert property (p_on_time) else $error("on-time select wrong");
    property p_peak_current_limit_select;
        logic [7:0] d;
        (wr_one, d = wr_data) |-> ##2 peak_current_limit_select == d[4];
    endproperty
    a_peak_current_limit_select: assert property (p_peak_current_limit_select) else $error("current limit select wrong");
    property p_ctrl_two;
        logic [7:0] d;
        (wr_two, d = wr_data) |-> ##2 full_duty_disable == d[7]
            && forced_switching_mode == d[6] && light_load_mode == !d[6];
    endproperty
    a_ctrl_two: assert property (p_ctrl_two) else $error("duty or mode wrong");
    property p_target;
        logic [7:0] d;
        (wr_vo, d = wr_data) |-> ##2 target_mv == ((d <= 8'h76) ? 11'h258
            : 11'h258 + 11'(d - 8'h77) * 11'h005);
    endproperty
    a_target: assert property (p_target) else $error("target voltage wrong");
    property p_reg_off;
        wr_one && wr_data[1:0] == 2'b00 |-> ##[2:4] !regulator_on;
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("regulator stays on");
    property p_discharge;
        output_discharge_on |-> !regulator_on;
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge while on");
    property p_latch;
        $rose(latch_off) |-> $past(overtemperature);
    endproperty
    a_latch: assert property (p_latch) else $error("latch without overheat");
    property p_ramp;
        regulator_on && $past(regulator_on) && $changed(applied_mv) |->
            (applied_mv == $past(applied_mv) + 11'h005)
            || (applied_mv + 11'h005 == $past(applied_mv));
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step not one code");
    property p_unmapped;
        rd_req && addr_r > REG_VOUT_CODE |-> ##1 rd_ack && rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reserved;
        rd_req && addr_r == REG_CTRL_ONE |-> ##1 rd_ack && !rd_data[5];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    c_on: cover property ($rose(regulator_on));
    c_latch: cover property ($rose(latch_off));
    c_unmapped: cover property (rd_req && addr_r > REG_VOUT_CODE);
endmodule // buck_regs_asserts

bind buck_regulator_control_registers buck_regs_asserts u_asserts (
    .clk, .sys_rst, .cmd_valid, .cmd_byte, .wr_valid, .wr_data, .rd_req, .rd_data, .rd_ack,
    .overtemperature, .on_time_select, .peak_current_limit_select, .full_duty_disable,
    .forced_switching_mode, .light_load_mode, .regulator_on, .latch_off,
    .output_discharge_on, .target_mv, .applied_mv
);

`default_nettype wire

// >>> tb/host_model.sv
// Purpose: host that selects, writes and reads the control registers
// Assumes: strobes change just after a rising edge
// Notes:   released buses show inverted data
`default_nettype none

module host_model (
    input  wire logic       clk,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic            wr_valid,
    output logic [7:0]      wr_data,
    output logic            rd_req,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        wr_valid  = 1'b0;
        wr_data   = 8'h00;
        rd_req    = 1'b0;
    end

    task automatic sel(input logic [7:0] c);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_byte  <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~c;
    endtask

    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        sel(c);
        wr_valid <= 1'b1;
        wr_data  <= d;
        @(posedge clk);
        wr_valid <= 1'b0;
        wr_data  <= ~d;
    endtask

    // bounded wait: a lost answer cannot hang the run
    task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic ok);
        int i;
        sel(c);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        ok = 1'b0;
        d  = 8'h00;
        for (i = 0; i < 3 && !ok; i++)
        begin
            @(negedge clk);
            ok = (rd_ack === 1'b1);
            d  = rd_data;
        end
    endtask
endmodule // host_model

`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the regulator control register bank
// Assumes: turn-on delays cut to 10..40 cycles
// Notes:   random data from a fixed-seed lfsr, corner cases by hand
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import buck_regs_pkg::*;

    localparam int DLY [4] = '{10, 20, 30, 40};
    logic        clk = 1'b0, sys_rst = 1'b1, enable_pin = 1'b0, overtemperature = 1'b0;
    logic        cmd_valid, wr_valid, rd_req, rd_ack, ok;
    logic [7:0]  cmd_byte, wr_data, rd_data, d;
    logic [1:0]  on_time_select;
    logic        peak_current_limit_select, full_duty_disable, forced_switching_mode;
    logic        light_load_mode, regulator_on, latch_off, output_discharge_on;
    logic [10:0] target_mv, applied_mv;
    logic [7:0]  m [3];
    logic [31:0] seed = 32'h0000_5546;
    int          n_fail = 0, n_compared = 0, i, n;

    always #10 clk = ~clk;

    buck_regulator_control_registers #(
        .FACTORY_CTRL_ONE (8'hFF), .FACTORY_CTRL_TWO (8'hFF), .FACTORY_VOUT (8'hB3),
        .DELAY0_CYCLES (18'(DLY[0])), .DELAY1_CYCLES (18'(DLY[1])),
        .DELAY2_CYCLES (18'(DLY[2])), .DELAY3_CYCLES (18'(DLY[3]))
    ) DUT (.*);
    host_model host (.*);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [10:0] mv_of(input logic [7:0] c);
        return (c <= 8'h76) ? 11'h258 : 11'h258 + 11'(c - 8'h77) * 11'h005;
    endfunction

    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkt(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // random upper command bits must not matter
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        seed = lfsr(seed);
        host.wr({seed[7:6], a}, v);
        if (a <= 6'h02)
            m[a[1:0]] = (a == 6'h00) ? (v & 8'hDF) : v;
    endtask
    task automatic rchk(input logic [5:0] a);
        host.rd({seed[9:8], a}, d, ok);
        chk("ack", 11'h001, 11'(ok));
        chk("rdata", 11'((a <= 6'h02) ? m[a[1:0]] : 8'h00), 11'(d));
    endtask
    task automatic outs;
        repeat (3) @(negedge clk);
        chk("on_time", 11'(m[0][7:6]), 11'(on_time_select));
        chk("peak_current_limit_select", 11'(m[0][4]), 11'(peak_current_limit_select));
        chk("duty", 11'(m[1][7]), 11'(full_duty_disable));
        chk("forced", 11'(m[1][6]), 11'(forced_switching_mode));
        chk("light", 11'(!m[1][6]), 11'(light_load_mode));
        chk("target", mv_of(m[2]), target_mv);
    endtask
    task automatic wait_on;
        for (n = 0; n < 100 && regulator_on !== 1'b1; n++)
            @(negedge clk);
    endtask
    task automatic gap(input int exp);
        int k;
        logic [10:0] v;
        @(negedge clk);
        v = applied_mv;
        for (k = 0; k < 2000 && applied_mv === v; k++)
            @(negedge clk);
        v = applied_mv;
        for (k = 0; k < 2000 && applied_mv === v; k++)
            @(negedge clk);
        chkt("ramp gap", exp, exp, k);
    endtask
    task automatic ot_pulse;
        @(posedge clk);
        overtemperature <= 1'b1;
        repeat (2) @(posedge clk);
        overtemperature <= 1'b0;
        repeat (3) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude;
    end

    initial
    begin
        // power-on view: factory fields kept, rest cleared
        m[0] = 8'hD0;
        m[1] = 8'h3F;
        m[2] = 8'hB3;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 3; i++)
            rchk(6'(i));
        outs;
        wr(6'h00, 8'hFF);
        rchk(6'h00);
        for (i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            d = seed[2] ? {6'h00, seed[1:0]} : {2'b00, seed[5:0]};
            wr(d[5:0], seed[15:8]);
            rchk(d[5:0]);
            outs;
        end
        for (i = 0; i < 3; i++)
            rchk(6'(i));
        foreach (DLY[i])
        begin
            d = {i[1:0], 2'b00, i[1:0], 2'b00};
            wr(6'h01, 8'h00);
            wr(6'h00, d);
            outs;
            wr(6'h00, d | 8'h01);
            wait_on;
            chkt("delay", DLY[i] + 1, DLY[i] + 3, n);
            wr(6'h00, d);
            repeat (4) @(negedge clk);
            chk("off", 11'h000, 11'(regulator_on));
        end
        wr(6'h00, 8'h03);
        repeat (60) @(negedge clk);
        chk("pin off", 11'h000, 11'(regulator_on));
        @(posedge clk);
        enable_pin <= 1'b1;
        wait_on;
        chk("pin on", 11'h001, 11'(regulator_on));
        @(posedge clk);
        enable_pin <= 1'b0;
        repeat (4) @(negedge clk);
        chk("pin drop", 11'h000, 11'(regulator_on));
        foreach (m[i])
        begin
            wr(6'h02, (i == 0) ? 8'hFF : (i == 1) ? 8'h76 : 8'h77);
            outs;
        end
        wr(6'h02, 8'h78);
        wr(6'h01, 8'h10);
        outs;
        chk("discharge", 11'h001, 11'(output_discharge_on));
        wr(6'h00, 8'h01);
        wait_on;
        repeat (2) @(negedge clk);
        chk("no discharge", 11'h000, 11'(output_discharge_on));
        wr(6'h02, 8'h80);
        gap(50);
        for (n = 0; n < 600 && applied_mv !== 11'h285; n++)
            @(negedge clk);
        chk("applied", 11'h285, applied_mv);
        wr(6'h01, 8'h13);
        wr(6'h02, 8'h90);
        gap(200);
        ot_pulse;
        chk("latch now", 11'h001, 11'(latch_off));
        wr(6'h00, 8'h00);
        wr(6'h01, 8'h20);
        wr(6'h00, 8'h01);
        wait_on;
        for (i = 1; i <= 4; i++)
        begin
            ot_pulse;
            chk("latch fourth", 11'(i == 4), 11'(latch_off));
        end
        conclude;
    end
endmodule // tb_top

`default_nettype wire
